// file: include/sync_serial_port_pkg.sv
// constants and types shared by the serial port design files
package sync_serial_port_pkg;
   localparam int BYTE_W = 8;
   localparam int RATE_CNT_W = 10;
   // mode select codes held in the control register
   localparam logic [3:0] MODE_DIV4 = 4'h0;
   localparam logic [3:0] MODE_DIV16 = 4'h1;
   localparam logic [3:0] MODE_DIV64 = 4'h2;
   localparam logic [3:0] MODE_TIMER = 4'h3;
   localparam logic [3:0] MODE_SLV_SS = 4'h4;
   localparam logic [3:0] MODE_SLV_NOSS = 4'h5;
   localparam logic [3:0] MODE_BAUD = 4'ha;
   // half serial clock periods in system clocks
   localparam logic [RATE_CNT_W-1:0] HALF_DIV4 = 10'h002;
   localparam logic [RATE_CNT_W-1:0] HALF_DIV16 = 10'h008;
   localparam logic [RATE_CNT_W-1:0] HALF_DIV64 = 10'h020;
   localparam logic [RATE_CNT_W-1:0] RATE_ONE = 10'h001;
   // control register layout
   localparam int CTL_WRITE_COLLISION_FLAG = 7;
   localparam int CTL_EN = 5;
   localparam int CTL_CKP = 4;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] CTRL_WMASK = 8'h3f;
   // status register layout
   localparam int STAT_SMP = 7;
   localparam int STAT_CKE = 6;
   localparam int STAT_BF = 0;
   localparam logic [7:0] STAT_RESET = 8'h00;
   localparam logic [7:0] STAT_WMASK = 8'hc0;
   localparam logic [7:0] BUF_RESET = 8'h00;
   // master edge sequencing, counted in half clock periods
   localparam logic [4:0] EDGE_LAST = 5'd16;
   localparam logic [4:0] SHIFT_LIMIT = 5'd15;
   localparam logic [4:0] SAMPLE_SPAN = 5'd14;
   localparam logic [2:0] BIT_LAST = 3'd7;
   typedef enum logic [1:0] {
      M_IDLE = 2'b01,
      M_RUN = 2'b10
   } master_state_t;
endpackage : sync_serial_port_pkg

// file: hw/spi_rate_gen.sv
// master serial clock half-period tick generator
`timescale 1ns/1ns
module spi_rate_gen #(
   parameter int CNT_W = sync_serial_port_pkg::RATE_CNT_W
) (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic run_i,
   input wire logic [3:0] mode_i,
   input wire logic [7:0] baud_i,
   input wire logic timer_tick_i,
   output logic tick_o
);
   import sync_serial_port_pkg::*;

   if (CNT_W < RATE_CNT_W) begin : g_bad_width
      $error("spi_rate_gen: CNT_W too small for baud divider");
   end

   logic [CNT_W-1:0] cnt;
   logic [CNT_W-1:0] half;
   logic [CNT_W-1:0] baud_half;
   wire use_timer = (mode_i == MODE_TIMER);
   wire at_end = (cnt == half - CNT_W'(RATE_ONE));

   // baud mode: Fosc/(4*(n+1)) means a half period of 2*(n+1) clocks
   assign baud_half = CNT_W'({({2'b00, baud_i} + RATE_ONE[8:0]), 1'b0});
   assign half = (mode_i == MODE_DIV16) ? CNT_W'(HALF_DIV16) :
                 (mode_i == MODE_DIV64) ? CNT_W'(HALF_DIV64) :
                 (mode_i == MODE_BAUD) ? baud_half : CNT_W'(HALF_DIV4);

   always_ff @(posedge sys_clk_i) begin
      if (rst_i || !run_i) begin
         cnt <= '0;
         tick_o <= 1'b0;
      end else if (use_timer) begin
         cnt <= '0;
         tick_o <= timer_tick_i;
      end else begin
         cnt <= at_end ? '0 : cnt + CNT_W'(RATE_ONE);
         tick_o <= at_end;
      end
   end
endmodule : spi_rate_gen

// file: hw/sync_serial_port.sv
// spi master/slave serial port with byte buffer and status flags
`timescale 1ns/1ns
// Operation
// - eight-bit shift register, MSB leaves first, incoming bit enters at LSB.
// - data shifts out on the chosen clock edge, captured on the opposite edge, or on the shift edge when a master's sample phase is set.
// - completed byte copied to the buffer and interrupt flag set.
// - buffer write loads buffer and shift register together.
// - write during a transfer is dropped, sets collision flag; blocked until cleared.
// - buffer-full set on received byte, cleared by buffer read.
// - receive double-buffered so next byte can shift before the read.
// - enable bit hands pins to the port; reconfigure by disable, rewrite, enable.
// - control selects role, idle polarity, rate, select mode; status top bits select sample phase, clock edge.
// - master clocks a byte right after a buffer write.
// - master with output unused still shifts in and flags each byte.
// - master rate is clock over 4, 16, 64, half timer, or baud reload.
// - with edge select set, output bit valid before the first clock edge.
// - slave shifts on external clock pulses, flags after the last bit.
// - slave samples the clock pin through the system-clock synchroniser.
// - unselected slave ignores clock and data and does not drive output.
// - status low six bits read-only, top two bits read and write.
// - select-controlled slave drives output only while select is low.
// - select high on a select-controlled slave, or enable clear, forces the bit counter to zero.
module sync_serial_port (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic ctrl_wr_i,
   input wire logic [7:0] ctrl_wdata_i,
   input wire logic stat_wr_i,
   input wire logic [7:0] stat_wdata_i,
   input wire logic [7:0] baud_reload_value_i,
   input wire logic buf_wr_i,
   input wire logic [sync_serial_port_pkg::BYTE_W-1:0] buf_wdata_i,
   input wire logic buf_rd_i,
   input wire logic int_clear_i,
   input wire logic timer_tick_i,
   input wire logic sck_i,
   input wire logic sdi_i,
   input wire logic ss_n_i,
   output logic [7:0] port_control_one_o,
   output logic [7:0] port_status_reg_o,
   output logic [sync_serial_port_pkg::BYTE_W-1:0] port_data_buffer_o,
   output logic port_interrupt_flag_o,
   output logic sck_o,
   output logic sck_oe_n_o,
   output logic sdo_o,
   output logic sdo_oe_n_o
);
   import sync_serial_port_pkg::*;

   if (BYTE_W != 8) begin : g_bad_byte
      $error("sync_serial_port: byte width must be 8");
   end

   master_state_t state;
   master_state_t next_state;
   logic [BYTE_W-1:0] port_shift_register;
   logic [4:0] edge_k;
   logic [2:0] bit_cnt;
   logic [2:0] sync1;
   logic [2:0] sync2;
   logic sck_q;
   logic tick;
   logic [7:0] next_ctrl;
   logic [7:0] next_status;

   // pin synchronisers: sck, sdi, ss_n
   wire [2:0] pin_raw = {sck_i, sdi_i, ss_n_i};
   genvar gi;
   for (gi = 0; gi < 3; gi++) begin : g_sync
      always_ff @(posedge sys_clk_i) begin
         sync1[gi] <= pin_raw[gi];
         sync2[gi] <= sync1[gi];
      end
   end
   wire sck_s = sync2[2];
   wire sdi_s = sync2[1];
   wire ss_n_s = sync2[0];

   // configuration decode
   wire [3:0] port_mode_select = port_control_one_o[3:0];
   wire port_enable_bit = port_control_one_o[CTL_EN];
   wire clock_idle_polarity = port_control_one_o[CTL_CKP];
   wire write_collision_flag = port_control_one_o[CTL_WRITE_COLLISION_FLAG];
   wire input_sample_phase = port_status_reg_o[STAT_SMP];
   wire clock_edge = port_status_reg_o[STAT_CKE];
   wire buffer_full_flag = port_status_reg_o[STAT_BF];
   wire mode_master = (port_mode_select == MODE_DIV4) || (port_mode_select == MODE_DIV16) ||
                      (port_mode_select == MODE_DIV64) || (port_mode_select == MODE_TIMER) ||
                      (port_mode_select == MODE_BAUD);
   wire ss_ctl = (port_mode_select == MODE_SLV_SS);
   wire mode_slave = ss_ctl || (port_mode_select == MODE_SLV_NOSS);
   wire is_master = port_enable_bit && mode_master;
   wire is_slave = port_enable_bit && mode_slave;
   wire slave_sel = is_slave && (!ss_ctl || !ss_n_s);
   wire slave_reset = !port_enable_bit || (is_slave && ss_ctl && ss_n_s);
   wire running = (state == M_RUN);

   // master edge sequencing
   wire m_step = tick && running;
   wire [4:0] m_first = 5'({4'h0, ~clock_edge} + {4'h0, input_sample_phase});
   wire m_sample = m_step && (edge_k[0] == m_first[0]) && (edge_k >= m_first) &&
                   (edge_k <= m_first + SAMPLE_SPAN);
   wire m_shift = m_step && (edge_k < SHIFT_LIMIT) && (clock_edge ? edge_k[0] : ~edge_k[0]);
   wire m_toggle = m_step && (edge_k < EDGE_LAST);
   wire m_done = m_step && (edge_k == EDGE_LAST);

   // slave edge detection on the synchronised clock
   wire lead_edge = slave_sel && (sck_q == clock_idle_polarity) && (sck_s != clock_idle_polarity);
   wire trail_edge = slave_sel && (sck_q != clock_idle_polarity) && (sck_s == clock_idle_polarity);
   wire s_sample = clock_edge ? lead_edge : trail_edge;
   wire s_shift = clock_edge ? trail_edge : lead_edge;
   wire s_done = s_sample && (bit_cnt == BIT_LAST);

   wire sample = m_sample || s_sample;
   wire shift_out = m_shift || s_shift;
   wire [BYTE_W-1:0] shift_in_val = sample ? {port_shift_register[BYTE_W-2:0], sdi_s} :
                                    port_shift_register;
   wire complete = m_done || s_done;

   // buffer write acceptance
   wire busy = running || (is_slave && (bit_cnt != 3'd0));
   wire collide = buf_wr_i && busy;
   wire accept = buf_wr_i && !busy && !write_collision_flag;

   spi_rate_gen u_rate (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .run_i(running),
      .mode_i(port_mode_select),
      .baud_i(baud_reload_value_i),
      .timer_tick_i(timer_tick_i),
      .tick_o(tick)
   );

   // master sequencer
   always_comb begin
      next_state = state;
      case (state)
         M_IDLE: begin
            if (accept && is_master) begin
               next_state = M_RUN;
            end
         end
         M_RUN: begin
            if (!is_master || m_done) begin
               next_state = M_IDLE;
            end
         end
         default: next_state = M_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         state <= M_IDLE;
         edge_k <= 5'd0;
      end else begin
         state <= next_state;
         edge_k <= (state == M_IDLE) ? 5'd0 : (m_step ? edge_k + 5'd1 : edge_k);
      end
   end

   // register write decode
   always_comb begin
      next_ctrl = port_control_one_o;
      if (ctrl_wr_i) begin
         next_ctrl = (ctrl_wdata_i & CTRL_WMASK) | (port_control_one_o & ~CTRL_WMASK);
         next_ctrl[CTL_WRITE_COLLISION_FLAG] = ctrl_wdata_i[CTL_WRITE_COLLISION_FLAG] && write_collision_flag;
      end
      if (collide) begin
         next_ctrl[CTL_WRITE_COLLISION_FLAG] = 1'b1;
      end
      next_status = port_status_reg_o;
      if (stat_wr_i) begin
         next_status = (stat_wdata_i & STAT_WMASK) | (port_status_reg_o & ~STAT_WMASK);
      end
      if (buf_rd_i) begin
         next_status[STAT_BF] = 1'b0;
      end
      if (complete) begin
         next_status[STAT_BF] = 1'b1;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         port_control_one_o <= CTRL_RESET;
         port_status_reg_o <= STAT_RESET;
      end else begin
         port_control_one_o <= next_ctrl;
         port_status_reg_o <= next_status;
      end
   end

   // shift register and receive buffer
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         port_shift_register <= BUF_RESET;
         port_data_buffer_o <= BUF_RESET;
      end else begin
         if (accept) begin
            port_shift_register <= buf_wdata_i;
            port_data_buffer_o <= buf_wdata_i;
         end else begin
            port_shift_register <= shift_in_val;
            if (complete) begin
               port_data_buffer_o <= shift_in_val;
            end
         end
      end
   end

   // interrupt flag, set wins over clear
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         port_interrupt_flag_o <= 1'b0;
      end else begin
         port_interrupt_flag_o <= complete || (port_interrupt_flag_o && !int_clear_i);
      end
   end

   // slave bit counter
   always_ff @(posedge sys_clk_i) begin
      if (rst_i || slave_reset) begin
         bit_cnt <= 3'd0;
      end else if (s_sample) begin
         bit_cnt <= bit_cnt + 3'd1;
      end
      sck_q <= sck_s;
   end

   // pin drivers
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         sck_o <= 1'b0;
         sck_oe_n_o <= 1'b1;
         sdo_o <= 1'b0;
         sdo_oe_n_o <= 1'b1;
      end else begin
         sck_oe_n_o <= !is_master;
         sdo_oe_n_o <= !(is_master || slave_sel);
         if (!running) begin
            sck_o <= clock_idle_polarity;
         end else if (m_toggle) begin
            sck_o <= ~sck_o;
         end
         if (accept) begin
            sdo_o <= buf_wdata_i[BYTE_W-1];
         end else if (shift_out) begin
            sdo_o <= sample ? port_shift_register[BYTE_W-2] : port_shift_register[BYTE_W-1];
         end
      end
   end

   // sck toggle counter watched by the assertions
   logic [4:0] tog_cnt;
   always_ff @(posedge sys_clk_i) begin
      if (rst_i || accept) begin
         tog_cnt <= 5'd0;
      end else if (m_toggle) begin
         tog_cnt <= tog_cnt + 5'd1;
      end
   end

   a_load_both: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      accept |=> (port_data_buffer_o == $past(buf_wdata_i)) && (port_shift_register == $past(buf_wdata_i)))
      else $error("buffer write did not load both registers");
   a_write_collision_flag_set: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      collide |=> port_control_one_o[CTL_WRITE_COLLISION_FLAG])
      else $error("collision flag not set");
   a_write_collision_flag_block: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (buf_wr_i && write_collision_flag && !complete) |=> $stable(port_data_buffer_o))
      else $error("write accepted while collision flag set");
   a_rx_flags: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      complete |=> port_status_reg_o[STAT_BF] && port_interrupt_flag_o &&
                   (port_data_buffer_o == $past(shift_in_val)))
      else $error("received byte not posted");
   a_bf_clear: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (buf_rd_i && !complete) |=> !port_status_reg_o[STAT_BF])
      else $error("buffer read did not clear full flag");
   a_master_start: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (accept && is_master && !ctrl_wr_i && (port_mode_select != MODE_TIMER)) |=>
      running ##[1:520] (sck_o != clock_idle_polarity))
      else $error("master did not start clocking");
   a_eight_clocks: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      m_done |-> (tog_cnt == EDGE_LAST) && (sck_o == clock_idle_polarity))
      else $error("master clock count wrong at end of byte");
   a_sdo_float: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (is_slave && ss_ctl && ss_n_s && !ctrl_wr_i) |=> sdo_oe_n_o)
      else $error("slave drives output while deselected");
   a_bitcnt_reset: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      slave_reset |=> (bit_cnt == 3'd0))
      else $error("bit counter not cleared by port reset");
   a_msb_first: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (accept && clock_edge) |=> (sdo_o == $past(buf_wdata_i[BYTE_W-1])))
      else $error("msb not presented before first edge");
   a_lsb_in: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (sample && !accept) |=> (port_shift_register[0] == $past(sdi_s)))
      else $error("sampled bit not entered at lsb");
   a_write_collision_flag_hold: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (write_collision_flag && !(ctrl_wr_i && !ctrl_wdata_i[CTL_WRITE_COLLISION_FLAG])) |=> port_control_one_o[CTL_WRITE_COLLISION_FLAG])
      else $error("collision flag lost without clear");
   a_write_collision_flag_clear: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (ctrl_wr_i && !ctrl_wdata_i[CTL_WRITE_COLLISION_FLAG] && !collide) |=> !port_control_one_o[CTL_WRITE_COLLISION_FLAG])
      else $error("collision flag not cleared by write");
   a_slave_collide: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (buf_wr_i && is_slave && (bit_cnt != 3'd0)) |=> port_control_one_o[CTL_WRITE_COLLISION_FLAG])
      else $error("write during slave byte not flagged");
   a_bf_hold: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (buffer_full_flag && !buf_rd_i) |=> port_status_reg_o[STAT_BF])
      else $error("buffer full lost without read");
   a_irq_hold: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (port_interrupt_flag_o && !int_clear_i) |=> port_interrupt_flag_o)
      else $error("interrupt flag lost without clear");
   a_irq_cause: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (!port_interrupt_flag_o && !complete) |=> !port_interrupt_flag_o)
      else $error("interrupt flag set without byte");
   a_stat_low_ro: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (port_status_reg_o[5:1] == 5'h00))
      else $error("read-only status bits changed");
   a_stat_top_rw: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      stat_wr_i |=> (port_status_reg_o[7:6] == $past(stat_wdata_i[7:6])))
      else $error("status top bits not written");
   a_ctrl_bit6: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (port_control_one_o[6] == 1'b0))
      else $error("unused control bit set");
   a_ctrl_write: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      ctrl_wr_i |=> (port_control_one_o[5:0] == $past(ctrl_wdata_i[5:0])))
      else $error("control bits not written");
   a_sck_idle: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      !running |=> (sck_o == $past(clock_idle_polarity)))
      else $error("serial clock not at idle level");
   a_sck_release: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      !is_master |=> sck_oe_n_o)
      else $error("clock pin driven outside master role");
   a_sck_drive: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      is_master |=> !sck_oe_n_o)
      else $error("clock pin not driven in master role");
   a_sdo_drive: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      slave_sel |=> !sdo_oe_n_o)
      else $error("selected slave does not drive output");
   a_unsel_quiet: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (!slave_sel && !running && !buf_wr_i) |=> $stable(port_shift_register))
      else $error("unselected port shifted data");
   a_done_stop: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      m_done |=> !running)
      else $error("master kept running after byte");
   a_bit_count: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (s_sample && !slave_reset) |=> (bit_cnt == $past(bit_cnt) + 3'd1))
      else $error("slave bit counter did not advance");
endmodule : sync_serial_port

// file: testbench/spi_partner.sv
// far side model: slave for the port's master, master for the port's slave
`timescale 1ns/1ns
module spi_partner (
   input wire logic sys_clk_i,
   input wire logic m_sck_i,
   input wire logic m_sdo_i,
   input wire logic m_sdo_oe_n_i,
   output logic sck_o,
   output logic ss_n_o,
   output logic sdi_o,
   output logic [7:0] got_o,
   output logic [3:0] edges_o
);
   logic [7:0] sh = 8'h00;
   logic drv = 1'b0;
   logic mdat = 1'b0;
   logic last = 1'b0;
   wire line = m_sdo_oe_n_i ? ~last : m_sdo_i;
   initial begin
      sck_o = 1'b0;
      ss_n_o = 1'b1;
      got_o = 8'h00;
      edges_o = 4'h0;
   end
   assign sdi_o = drv ? mdat : sh[7];
   always @(posedge sys_clk_i) begin
      if (!m_sdo_oe_n_i) last <= m_sdo_i;
   end
   // slave side: capture on leading edge, shift out on trailing edge
   always @(posedge m_sck_i) begin
      got_o <= {got_o[6:0], line};
      edges_o <= edges_o + 4'h1;
   end
   always @(negedge m_sck_i) sh <= {sh[6:0], 1'b0};
   task automatic arm(input logic [7:0] rep);
      sh = rep;
      edges_o = 4'h0;
   endtask : arm
   // master side, leading edge drives, trailing edge samples
   task automatic xfer(input logic [7:0] tx, input int nbits);
      @(posedge sys_clk_i);
      ss_n_o <= 1'b0;
      drv <= 1'b1;
      repeat (8) @(posedge sys_clk_i);
      for (int i = 7; i > 7 - nbits; i--) begin
         sck_o <= 1'b1;
         mdat <= tx[i];
         repeat (8) @(posedge sys_clk_i);
         got_o <= {got_o[6:0], line};
         sck_o <= 1'b0;
         repeat (8) @(posedge sys_clk_i);
      end
      ss_n_o <= 1'b1;
      drv <= 1'b0;
   endtask : xfer
endmodule : spi_partner

// file: testbench/sync_serial_port_tb_top.sv
// self-checking bench for the serial port
`timescale 1ns/1ns
module sync_serial_port_tb_top;
   import sync_serial_port_pkg::*;
   logic sys_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [4:0] stb = 5'h00;
   logic [7:0] wd = 8'h00;
   logic timer_tick_i = 1'b0;
   logic [3:0] tcnt = 4'h0;
   int error_cnt = 0;
   int checked = 0;
   int cycles = 0;
   logic [7:0] ctrl, stat, buffer;
   logic flag, sck_o, sck_oe_n, sdo, sdo_oe_n, p_sck, p_ss_n, p_sdi;
   logic [7:0] got;
   logic [3:0] edges;
   logic [3:0] md [5] = '{MODE_DIV4, MODE_DIV16, MODE_DIV64, MODE_TIMER, MODE_BAUD};
   int pr [5] = '{4, 16, 64, 10, 12};
   sync_serial_port sync_serial_port_inst (
      .sys_clk_i(sys_clk_i), .rst_i(rst_i), .ctrl_wr_i(stb[0]), .ctrl_wdata_i(wd),
      .stat_wr_i(stb[1]), .stat_wdata_i(wd), .baud_reload_value_i(8'h02), .buf_wr_i(stb[2]),
      .buf_wdata_i(wd), .buf_rd_i(stb[3]), .int_clear_i(stb[4]), .timer_tick_i(timer_tick_i),
      .sck_i(p_sck), .sdi_i(p_sdi), .ss_n_i(p_ss_n), .port_control_one_o(ctrl),
      .port_status_reg_o(stat), .port_data_buffer_o(buffer), .port_interrupt_flag_o(flag),
      .sck_o(sck_o), .sck_oe_n_o(sck_oe_n), .sdo_o(sdo), .sdo_oe_n_o(sdo_oe_n));
   spi_partner spi_partner_inst (
      .sys_clk_i(sys_clk_i), .m_sck_i(sck_o), .m_sdo_i(sdo), .m_sdo_oe_n_i(sdo_oe_n),
      .sck_o(p_sck), .ss_n_o(p_ss_n), .sdi_o(p_sdi), .got_o(got), .edges_o(edges));
   initial begin
      forever #10 sys_clk_i = ~sys_clk_i;
   end
   always @(posedge sys_clk_i) begin
      tcnt <= (tcnt == 4'h4) ? 4'h0 : tcnt + 4'h1;
      timer_tick_i <= (tcnt == 4'h4);
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         error_cnt = error_cnt + 1;
         report_and_stop();
      end
   end
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checked = checked + 1;
      if (seen !== exp) begin
         $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
         error_cnt = error_cnt + 1;
      end
   endtask : chk
   task automatic op(input int k, input logic [7:0] d);
      @(posedge sys_clk_i);
      stb[k] <= 1'b1;
      wd <= d;
      @(posedge sys_clk_i);
      stb[k] <= 1'b0;
      #1;
   endtask : op
   task automatic wait_sck(input logic v, inout int n);
      while (sck_o !== v && n < 5000) begin
         @(posedge sys_clk_i);
         #1;
         n++;
      end
   endtask : wait_sck
   task automatic wait_flag();
      for (int i = 0; i < 3000 && flag !== 1'b1; i++) begin
         @(posedge sys_clk_i);
         #1;
      end
      chk(16'(flag), 16'h0001);
   endtask : wait_flag
   task automatic mxfer(input logic [3:0] m, input logic [7:0] tx, input logic [7:0] rep, input int per);
      int n;
      op(0, 8'h00);
      op(0, {4'h2, m});
      op(4, 8'h00);
      spi_partner_inst.arm(rep);
      op(2, tx);
      chk(buffer, tx);
      chk(16'(sck_oe_n), 16'h0000);
      n = 0;
      wait_sck(1'b1, n);
      chk(16'(n <= per / 2 + 2), 16'h0001);
      n = 0;
      wait_sck(1'b0, n);
      wait_sck(1'b1, n);
      chk(16'(n), 16'(per));
      wait_flag();
      chk(got, tx);
      chk(16'(edges), 16'h0008);
      chk(16'(sck_o), 16'h0000);
      chk(16'(stat[STAT_BF]), 16'h0001);
      if (m != MODE_DIV4) chk(buffer, rep);
   endtask : mxfer
   task report_and_stop();
      $display("checked=%0d error_cnt=%0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : report_and_stop
   initial begin
      repeat (2) @(posedge sys_clk_i);
      rst_i <= 1'b0;
      #1;
      chk({ctrl, stat}, 16'h0000);
      chk({sck_oe_n, sdo_oe_n, flag}, 16'h0006);
      op(1, 8'hff);
      chk(stat, 8'hc0);
      op(0, 8'hff);
      chk(ctrl, 8'h3f);
      $display("test registers done");
      op(1, 8'h40);
      for (int i = 0; i < 5; i++) mxfer(md[i], 8'ha5 ^ 8'(i), 8'h3c + 8'(i), pr[i]);
      op(1, 8'hc0);
      mxfer(MODE_DIV16, 8'h5c, 8'he1, 16);
      $display("test master rates done");
      op(4, 8'h00);
      spi_partner_inst.arm(8'h77);
      op(2, 8'h11);
      op(2, 8'h22);
      chk(16'(ctrl[CTL_WRITE_COLLISION_FLAG]), 16'h0001);
      wait_flag();
      chk(buffer, 8'h77);
      op(2, 8'h33);
      chk(buffer, 8'h77);
      op(0, 8'h21);
      chk(ctrl, 8'h21);
      op(3, 8'h00);
      chk(16'(stat[STAT_BF]), 16'h0000);
      $display("test collision done");
      op(0, 8'h00);
      op(0, {4'h2, MODE_SLV_SS});
      op(1, 8'h00);
      op(4, 8'h00);
      op(2, 8'h5a);
      chk(16'(sdo_oe_n), 16'h0001);
      spi_partner_inst.xfer(8'hf0, 4);
      repeat (6) @(posedge sys_clk_i);
      #1;
      chk({7'h00, sdo_oe_n, 7'h00, flag}, 16'h0100);
      op(2, 8'hc3);
      chk(buffer, 8'hc3);
      spi_partner_inst.xfer(8'h96, 8);
      repeat (6) @(posedge sys_clk_i);
      #1;
      chk(16'(flag), 16'h0001);
      chk(buffer, 8'h96);
      chk(got, 8'hc3);
      op(0, 8'h00);
      op(0, {4'h2, MODE_SLV_NOSS});
      op(4, 8'h00);
      op(2, 8'h3e);
      chk(16'(sdo_oe_n), 16'h0000);
      spi_partner_inst.xfer(8'h69, 8);
      repeat (6) @(posedge sys_clk_i);
      #1;
      chk({7'h00, flag, buffer}, 16'h0169);
      chk(got, 8'h3e);
      $display("test slave done");
      report_and_stop();
   end
endmodule : sync_serial_port_tb_top
